// ---- identify_data_generator.sv ----
// Identification block word generator with Wishbone configuration registers
`timescale 1ns/10ps
module identify_data_generator (
    input  wire logic        i_clk,
    input  wire logic        i_arst_n,
    input  wire logic        i_wb_cyc,
    input  wire logic        i_wb_stb,
    input  wire logic        i_wb_we,
    input  wire logic [7:0]  i_wb_adr,
    input  wire logic [3:0]  i_wb_sel,
    input  wire logic [31:0] i_wb_dat,
    output logic      [31:0] o_wb_dat,
    output logic             o_wb_ack,
    input  wire logic        i_id_start,
    input  wire logic        i_id_next,
    output logic      [15:0] o_id_data,
    output logic             o_id_valid,
    output logic             o_id_busy
);

    // Reset release synchroniser
    logic rst_meta_r;
    logic rst_n_r;

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rst_meta_r <= 1'b0;
            rst_n_r    <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n_r    <= rst_meta_r;
        end
    end

    // Configuration registers
    logic [2:0]              ctrl_r;
    id_gen_pkg::geom_t       def_geom_r;
    id_gen_pkg::geom_t       cur_geom_r;
    logic [31:0]             total_r;
    logic [4:0]              ser_len_r;
    logic [5:0]              mdl_len_r;

    // Bus decode
    wire        wb_req    = i_wb_cyc & i_wb_stb & ~o_wb_ack;
    wire        wb_wr     = i_wb_cyc & i_wb_stb & i_wb_we & o_wb_ack;
    wire        hit_ctrl  = (i_wb_adr == id_gen_pkg::CTRL_OFS);
    wire        hit_dch   = (i_wb_adr == id_gen_pkg::DEF_CH_OFS);
    wire        hit_dspt  = (i_wb_adr == id_gen_pkg::DEF_SPT_OFS);
    wire        hit_tot   = (i_wb_adr == id_gen_pkg::TOTAL_OFS);
    wire        hit_cch   = (i_wb_adr == id_gen_pkg::CUR_CH_OFS);
    wire        hit_cspt  = (i_wb_adr == id_gen_pkg::CUR_SPT_OFS);
    wire        hit_len   = (i_wb_adr == id_gen_pkg::STRLEN_OFS);
    wire        hit_stat  = (i_wb_adr == id_gen_pkg::STATUS_OFS);
    wire        hit_str   = (i_wb_adr == id_gen_pkg::STRWR_OFS);
    wire [31:0] bmask     = {{8{i_wb_sel[3]}}, {8{i_wb_sel[2]}},
                             {8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};
    wire        str_we    = wb_wr & hit_str & i_wb_sel[0] & i_wb_sel[1];

    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [31:0] m);
        merge = (old_v & ~m) | (new_v & m);
    endfunction : merge

    wire [31:0] ctrl_w    = {29'h0, ctrl_r};
    wire [31:0] dch_w     = {def_geom_r.heads, def_geom_r.cyl};
    wire [31:0] dspt_w    = {16'h0000, def_geom_r.spt};
    wire [31:0] cch_w     = {cur_geom_r.heads, cur_geom_r.cyl};
    wire [31:0] cspt_w    = {16'h0000, cur_geom_r.spt};
    wire [31:0] len_w     = {10'h0, mdl_len_r, 11'h0, ser_len_r};
    wire [31:0] ctrl_nxt  = merge(ctrl_w, i_wb_dat, bmask);
    wire [31:0] dch_nxt   = merge(dch_w, i_wb_dat, bmask);
    wire [31:0] dspt_nxt  = merge(dspt_w, i_wb_dat, bmask);
    wire [31:0] tot_nxt   = merge(total_r, i_wb_dat, bmask);
    wire [31:0] cch_nxt   = merge(cch_w, i_wb_dat, bmask);
    wire [31:0] cspt_nxt  = merge(cspt_w, i_wb_dat, bmask);
    wire [31:0] len_nxt   = merge(len_w, i_wb_dat, bmask);

    // Generator state
    id_gen_pkg::gen_state_t  state_r;
    logic [7:0]              widx_r;

    wire [31:0] status_w  = {15'h0, ctrl_r[id_gen_pkg::CTRL_MULT_BIT],
                             widx_r, 7'h0, o_id_busy};
    wire [31:0] rd_mux    = hit_ctrl ? ctrl_w   :
                            hit_dch  ? dch_w    :
                            hit_dspt ? dspt_w   :
                            hit_tot  ? total_r  :
                            hit_cch  ? cch_w    :
                            hit_cspt ? cspt_w   :
                            hit_len  ? len_w    :
                            hit_stat ? status_w : 32'h0000_0000;

    always_ff @(posedge i_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            o_wb_ack <= 1'b0;
            o_wb_dat <= 32'h0000_0000;
        end else begin
            o_wb_ack <= wb_req;
            o_wb_dat <= (wb_req & ~i_wb_we) ? rd_mux : 32'h0000_0000;
        end
    end

    always_ff @(posedge i_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            ctrl_r     <= id_gen_pkg::CTRL_RST;
            def_geom_r <= '0;
            cur_geom_r <= '0;
            total_r    <= 32'h0000_0000;
            ser_len_r  <= 5'h00;
            mdl_len_r  <= 6'h00;
        end else if (wb_wr) begin
            if (hit_ctrl) begin
                ctrl_r <= ctrl_nxt[2:0];
            end
            if (hit_dch) begin
                def_geom_r.cyl   <= dch_nxt[15:0];
                def_geom_r.heads <= dch_nxt[31:16];
            end
            if (hit_dspt) begin
                def_geom_r.spt <= dspt_nxt[15:0];
            end
            if (hit_tot) begin
                total_r <= tot_nxt;
            end
            if (hit_cch) begin
                cur_geom_r.cyl   <= cch_nxt[15:0];
                cur_geom_r.heads <= cch_nxt[31:16];
            end
            if (hit_cspt) begin
                cur_geom_r.spt <= cspt_nxt[15:0];
            end
            if (hit_len) begin
                ser_len_r <= (len_nxt[4:0] > id_gen_pkg::SER_BYTES) ?
                             id_gen_pkg::SER_BYTES : len_nxt[4:0];
                mdl_len_r <= (len_nxt[21:16] > id_gen_pkg::MDL_BYTES) ?
                             id_gen_pkg::MDL_BYTES : len_nxt[21:16];
            end
        end
    end

    // String field addressing
    wire       in_ser   = (widx_r >= id_gen_pkg::W_SER_FST) &&
                          (widx_r <= id_gen_pkg::W_SER_LST);
    wire       in_mdl   = (widx_r >= id_gen_pkg::W_MDL_FST) &&
                          (widx_r <= id_gen_pkg::W_MDL_LST);
    wire       in_fw    = (widx_r >= id_gen_pkg::W_FW_FST) &&
                          (widx_r <= id_gen_pkg::W_FW_LST);
    wire [7:0] ser_off  = 8'(widx_r - id_gen_pkg::W_SER_FST);
    wire [7:0] mdl_off  = 8'(widx_r - id_gen_pkg::W_MDL_FST);
    wire [6:0] ser_pos  = {ser_off[5:0], 1'b0};
    wire [6:0] mdl_pos  = {mdl_off[5:0], 1'b0};
    wire [6:0] ser_pad  = 7'(id_gen_pkg::SER_BYTES - ser_len_r);
    wire [6:0] ser_ch   = 7'(ser_pos - ser_pad);
    wire       ser_sp_h = (ser_pos < ser_pad);
    wire       ser_sp_l = (7'(ser_pos + 7'h01) < ser_pad);
    wire       mdl_sp_h = (mdl_pos >= {1'b0, mdl_len_r});
    wire       mdl_sp_l = (7'(mdl_pos + 7'h01) >= {1'b0, mdl_len_r});
    wire [6:0] mem_ra   = in_ser ? ser_ch : 7'(id_gen_pkg::MDL_BASE + mdl_pos);
    wire [6:0] mem_rb   = 7'(mem_ra + 7'h01);
    wire [7:0] mem_da;
    wire [7:0] mem_db;

    id_string_mem #(
        .AW        (id_gen_pkg::MEM_AW)
    ) u_str_mem (
        .i_clk     (i_clk),
        .i_we      (str_we),
        .i_waddr   (i_wb_dat[6:0]),
        .i_wdata   (i_wb_dat[15:8]),
        .i_raddr_a (mem_ra),
        .i_raddr_b (mem_rb),
        .o_rdata_a (mem_da),
        .o_rdata_b (mem_db)
    );

    wire [7:0] ser_hi   = ser_sp_h ? id_gen_pkg::SPACE_CHR : mem_da;
    wire [7:0] ser_lo   = ser_sp_l ? id_gen_pkg::SPACE_CHR : mem_db;
    wire [7:0] mdl_hi   = mdl_sp_h ? id_gen_pkg::SPACE_CHR : mem_da;
    wire [7:0] mdl_lo   = mdl_sp_l ? id_gen_pkg::SPACE_CHR : mem_db;

    wire [47:0] cap_full = 48'(cur_geom_r.cyl) *
                           48'(cur_geom_r.heads) *
                           48'(cur_geom_r.spt);
    wire [31:0] cur_cap  = cap_full[31:0];
    // even byte only 00h or 01h
    wire [7:0]  mult_lo  = ctrl_r[id_gen_pkg::CTRL_MULT_BIT] ?
                           id_gen_pkg::MULT_ONE : id_gen_pkg::MULT_NONE;
    wire [15:0] ena0_w   = id_gen_pkg::ENA0_VAL |
                           (16'(ctrl_r[id_gen_pkg::CTRL_SEC_BIT]) << id_gen_pkg::ENA0_SEC_BIT);
    wire [15:0] ena1_w   = id_gen_pkg::ENA1_VAL |
                           (16'(ctrl_r[id_gen_pkg::CTRL_APM_BIT]) << id_gen_pkg::ENA1_APM_BIT);

    logic [15:0] word_val;

    always_comb begin
        word_val = 16'h0000;
        if (in_ser) begin
            word_val = {ser_hi, ser_lo};
        end else if (in_mdl) begin
            word_val = {mdl_hi, mdl_lo};
        end else if (in_fw) begin
            word_val = id_gen_pkg::FW_VAL;
        end else begin
            case (widx_r)
                id_gen_pkg::W_GENCFG:   word_val = id_gen_pkg::GENCFG_VAL;
                id_gen_pkg::W_DEF_CYL:  word_val = def_geom_r.cyl;
                id_gen_pkg::W_DEF_HEAD: word_val = def_geom_r.heads;
                id_gen_pkg::W_BPS:      word_val = id_gen_pkg::BPS_VAL;
                id_gen_pkg::W_DEF_SPT:  word_val = def_geom_r.spt;
                id_gen_pkg::W_TOT_MSW:  word_val = total_r[31:16];
                id_gen_pkg::W_TOT_LSW:  word_val = total_r[15:0];
                id_gen_pkg::W_BUF_TYPE: word_val = id_gen_pkg::BUF_TYPE_V;
                id_gen_pkg::W_BUF_SIZE: word_val = id_gen_pkg::BUF_SIZE_V;
                id_gen_pkg::W_ECC:      word_val = id_gen_pkg::ECC_VAL;
                id_gen_pkg::W_MAX_MULT: word_val = id_gen_pkg::MAX_MULT_V;
                id_gen_pkg::W_DWORD:    word_val = id_gen_pkg::DWORD_VAL;
                id_gen_pkg::W_CAPS:     word_val = id_gen_pkg::CAPS_VAL;
                id_gen_pkg::W_PIO_TIM:  word_val = id_gen_pkg::PIO_TIM_V;
                id_gen_pkg::W_VALID:    word_val = id_gen_pkg::VALID_VAL;
                id_gen_pkg::W_CUR_CYL:  word_val = cur_geom_r.cyl;
                id_gen_pkg::W_CUR_HEAD: word_val = cur_geom_r.heads;
                id_gen_pkg::W_CUR_SPT:  word_val = cur_geom_r.spt;
                id_gen_pkg::W_CAP_LSW:  word_val = cur_cap[15:0];
                id_gen_pkg::W_CAP_MSW:  word_val = cur_cap[31:16];
                id_gen_pkg::W_MULT_SET: word_val = {id_gen_pkg::MULT_VALID, mult_lo};
                id_gen_pkg::W_LBA_LSW:  word_val = total_r[15:0];
                id_gen_pkg::W_LBA_MSW:  word_val = total_r[31:16];
                id_gen_pkg::W_ADV_PIO:  word_val = id_gen_pkg::ADV_PIO_V;
                id_gen_pkg::W_PIO_NOFC: word_val = id_gen_pkg::PIO_CYC_V;
                id_gen_pkg::W_PIO_FC:   word_val = id_gen_pkg::PIO_CYC_V;
                id_gen_pkg::W_SUP0:     word_val = id_gen_pkg::SUP0_VAL;
                id_gen_pkg::W_SUP1:     word_val = id_gen_pkg::SUP1_VAL;
                id_gen_pkg::W_SUP2:     word_val = id_gen_pkg::SUP2_VAL;
                id_gen_pkg::W_ENA0:     word_val = ena0_w;
                id_gen_pkg::W_ENA1:     word_val = ena1_w;
                id_gen_pkg::W_ENA2:     word_val = id_gen_pkg::ENA2_VAL;
                id_gen_pkg::W_TIDE:     word_val = id_gen_pkg::TIDE_VAL;
                id_gen_pkg::W_TPCM:     word_val = id_gen_pkg::TPCM_VAL;
                default:                word_val = 16'h0000;
            endcase
        end
    end

    // Word sequencer
    id_gen_pkg::gen_state_t  state_nxt;
    wire        last_word = (widx_r == id_gen_pkg::W_LAST);
    wire        consume   = (state_r == id_gen_pkg::ST_SERVE) && i_id_next;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            id_gen_pkg::ST_IDLE: begin
                if (i_id_start) begin
                    state_nxt = id_gen_pkg::ST_FETCH;
                end
            end
            id_gen_pkg::ST_FETCH: state_nxt = id_gen_pkg::ST_LOAD;
            id_gen_pkg::ST_LOAD:  state_nxt = id_gen_pkg::ST_SERVE;
            id_gen_pkg::ST_SERVE: begin
                if (i_id_next) begin
                    state_nxt = last_word ? id_gen_pkg::ST_IDLE : id_gen_pkg::ST_FETCH;
                end
            end
            default: state_nxt = id_gen_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge i_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            state_r <= id_gen_pkg::ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge i_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            widx_r <= 8'h00;
        end else if (state_r == id_gen_pkg::ST_IDLE) begin
            widx_r <= 8'h00;
        end else if (consume && !last_word) begin
            widx_r <= 8'(widx_r + 8'h01);
        end
    end

    always_ff @(posedge i_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            o_id_data  <= 16'h0000;
            o_id_valid <= 1'b0;
            o_id_busy  <= 1'b0;
        end else begin
            o_id_busy <= (state_nxt != id_gen_pkg::ST_IDLE);
            if (state_r == id_gen_pkg::ST_LOAD) begin
                o_id_data  <= word_val;
                o_id_valid <= 1'b1;
            end else if (consume) begin
                o_id_valid <= 1'b0;
            end
        end
    end

endmodule : identify_data_generator

// ---- id_gen_pkg.sv ----
// Shared constants and types for the identification word generator
package id_gen_pkg;

    // Wishbone register byte offsets
    localparam logic [7:0] CTRL_OFS     = 8'h00;
    localparam logic [7:0] DEF_CH_OFS   = 8'h04;
    localparam logic [7:0] DEF_SPT_OFS  = 8'h08;
    localparam logic [7:0] TOTAL_OFS    = 8'h0C;
    localparam logic [7:0] CUR_CH_OFS   = 8'h10;
    localparam logic [7:0] CUR_SPT_OFS  = 8'h14;
    localparam logic [7:0] STRLEN_OFS   = 8'h18;
    localparam logic [7:0] STATUS_OFS   = 8'h1C;
    localparam logic [7:0] STRWR_OFS    = 8'h20;

    // Control register bits and reset values
    localparam int         CTRL_MULT_BIT = 0;
    localparam int         CTRL_SEC_BIT  = 1;
    localparam int         CTRL_APM_BIT  = 2;
    localparam logic [2:0] CTRL_RST      = 3'h6;

    // Identification word addresses
    localparam logic [7:0] W_GENCFG   = 8'h00;
    localparam logic [7:0] W_DEF_CYL  = 8'h01;
    localparam logic [7:0] W_DEF_HEAD = 8'h03;
    localparam logic [7:0] W_BPT      = 8'h04;
    localparam logic [7:0] W_BPS      = 8'h05;
    localparam logic [7:0] W_DEF_SPT  = 8'h06;
    localparam logic [7:0] W_TOT_MSW  = 8'h07;
    localparam logic [7:0] W_TOT_LSW  = 8'h08;
    localparam logic [7:0] W_SER_FST  = 8'h0A;
    localparam logic [7:0] W_SER_LST  = 8'h13;
    localparam logic [7:0] W_BUF_TYPE = 8'h14;
    localparam logic [7:0] W_BUF_SIZE = 8'h15;
    localparam logic [7:0] W_ECC      = 8'h16;
    localparam logic [7:0] W_FW_FST   = 8'h17;
    localparam logic [7:0] W_FW_LST   = 8'h1A;
    localparam logic [7:0] W_MDL_FST  = 8'h1B;
    localparam logic [7:0] W_MDL_LST  = 8'h2E;
    localparam logic [7:0] W_MAX_MULT = 8'h2F;
    localparam logic [7:0] W_DWORD    = 8'h30;
    localparam logic [7:0] W_CAPS     = 8'h31;
    localparam logic [7:0] W_PIO_TIM  = 8'h33;
    localparam logic [7:0] W_VALID    = 8'h35;
    localparam logic [7:0] W_CUR_CYL  = 8'h36;
    localparam logic [7:0] W_CUR_HEAD = 8'h37;
    localparam logic [7:0] W_CUR_SPT  = 8'h38;
    localparam logic [7:0] W_CAP_LSW  = 8'h39;
    localparam logic [7:0] W_CAP_MSW  = 8'h3A;
    localparam logic [7:0] W_MULT_SET = 8'h3B;
    localparam logic [7:0] W_LBA_LSW  = 8'h3C;
    localparam logic [7:0] W_LBA_MSW  = 8'h3D;
    localparam logic [7:0] W_ADV_PIO  = 8'h40;
    localparam logic [7:0] W_PIO_NOFC = 8'h43;
    localparam logic [7:0] W_PIO_FC   = 8'h44;
    localparam logic [7:0] W_SUP0     = 8'h52;
    localparam logic [7:0] W_SUP1     = 8'h53;
    localparam logic [7:0] W_SUP2     = 8'h54;
    localparam logic [7:0] W_ENA0     = 8'h55;
    localparam logic [7:0] W_ENA1     = 8'h56;
    localparam logic [7:0] W_ENA2     = 8'h57;
    localparam logic [7:0] W_TIDE     = 8'hA3;
    localparam logic [7:0] W_TPCM     = 8'hA4;
    localparam logic [7:0] W_LAST     = 8'hFF;

    // Fixed word values
    localparam logic [15:0] GENCFG_VAL  = 16'h0000;
    localparam logic [15:0] BPS_VAL     = 16'h0240;
    localparam logic [15:0] BUF_TYPE_V  = 16'h0002;
    localparam logic [15:0] BUF_SIZE_V  = 16'h0002;
    localparam logic [15:0] ECC_VAL     = 16'h0004;
    localparam logic [15:0] FW_VAL      = 16'h2020;
    localparam logic [15:0] MAX_MULT_V  = 16'h0001;
    localparam logic [15:0] DWORD_VAL   = 16'h0000;
    localparam logic [15:0] CAPS_VAL    = 16'h0200;
    localparam logic [15:0] PIO_TIM_V   = 16'h0200;
    localparam logic [15:0] VALID_VAL   = 16'h0003;
    localparam logic [7:0]  MULT_VALID  = 8'h01;
    localparam logic [7:0]  MULT_ONE    = 8'h01;
    localparam logic [7:0]  MULT_NONE   = 8'h00;
    localparam logic [15:0] ADV_PIO_V   = 16'h0003;
    localparam logic [15:0] PIO_CYC_V   = 16'h0078;
    localparam logic [15:0] SUP0_VAL    = 16'h706A;
    localparam logic [15:0] SUP1_VAL    = 16'h400C;
    localparam logic [15:0] SUP2_VAL    = 16'h4000;
    localparam logic [15:0] ENA0_VAL    = 16'h7068;
    localparam logic [15:0] ENA1_VAL    = 16'h0004;
    localparam logic [15:0] ENA2_VAL    = 16'h4000;
    localparam logic [15:0] TIDE_VAL    = 16'h0082;
    localparam logic [15:0] TPCM_VAL    = 16'h001B;
    localparam int          ENA0_SEC_BIT = 1;
    localparam int          ENA1_APM_BIT = 3;

    // String field geometry
    localparam logic [7:0]  SPACE_CHR   = 8'h20;
    localparam logic [4:0]  SER_BYTES   = 5'h14;
    localparam logic [5:0]  MDL_BYTES   = 6'h28;
    localparam logic [6:0]  MDL_BASE    = 7'h40;
    localparam int          MEM_AW      = 7;

    typedef struct packed {
        logic [15:0] cyl;
        logic [15:0] heads;
        logic [15:0] spt;
    } geom_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_FETCH = 2'b01,
        ST_LOAD  = 2'b11,
        ST_SERVE = 2'b10
    } gen_state_t;

endpackage : id_gen_pkg

// ---- id_string_mem.sv ----
// Byte memory for serial and model strings, two registered read ports
`timescale 1ns/10ps
module id_string_mem #(
    parameter int AW = 7
) (
    input  wire logic          i_clk,
    input  wire logic          i_we,
    input  wire logic [AW-1:0] i_waddr,
    input  wire logic [7:0]    i_wdata,
    input  wire logic [AW-1:0] i_raddr_a,
    input  wire logic [AW-1:0] i_raddr_b,
    output logic      [7:0]    o_rdata_a,
    output logic      [7:0]    o_rdata_b
);

    logic [7:0] mem [0:(1<<AW)-1];

    always_ff @(posedge i_clk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
        o_rdata_a <= mem[i_raddr_a];
        o_rdata_b <= mem[i_raddr_b];
    end

endmodule : id_string_mem

// ---- id_gen_props.sv ----
// Port checks for the identification word generator
`timescale 1ns/10ps
module id_gen_props (
    input wire logic        i_clk,
    input wire logic        i_arst_n,
    input wire logic        i_wb_cyc,
    input wire logic        i_wb_stb,
    input wire logic        i_wb_we,
    input wire logic [7:0]  i_wb_adr,
    input wire logic [3:0]  i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    input wire logic [31:0] o_wb_dat,
    input wire logic        o_wb_ack,
    input wire logic        i_id_start,
    input wire logic        i_id_next,
    input wire logic [15:0] o_id_data,
    input wire logic        o_id_valid,
    input wire logic        o_id_busy
);
    logic [7:0] idx_r;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);
    // Index of the word on offer
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) idx_r <= 8'h00;
        else if (i_id_start && !o_id_busy) idx_r <= 8'h00;
        else if (o_id_valid && i_id_next) idx_r <= idx_r + 8'h01;
    end
    chk_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack)
        else $error("ack too long");
    chk_ack_answer: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
        else $error("ack missing");
    chk_rdat_idle: assert property (!o_wb_ack |-> o_wb_dat == 32'h0000_0000)
        else $error("read data outside ack");
    chk_start_answer: assert property (i_id_start && !o_id_busy |-> ##3 o_id_valid)
        else $error("first word late");
    chk_word_hold: assert property (o_id_valid && !i_id_next |=> o_id_valid && $stable(o_id_data))
        else $error("word not held");
    chk_next_answer: assert property (o_id_valid && i_id_next && idx_r != 8'hFF |=> !o_id_valid ##2 o_id_valid)
        else $error("next word timing");
    chk_mult_flag: assert property (o_id_valid && idx_r == 8'h3B |-> o_id_data[15:1] == 15'h0080)
        else $error("multiple word");
    chk_sup_marks: assert property (o_id_valid && idx_r inside {8'h53, 8'h54} |-> o_id_data[15:14] == 2'b01)
        else $error("supported mark");
    chk_ena_mark: assert property (o_id_valid && idx_r == 8'h57 |-> o_id_data == 16'h4000)
        else $error("enabled mark");
endmodule : id_gen_props
bind identify_data_generator id_gen_props u_props (.i_clk(i_clk), .i_arst_n(i_arst_n),
    .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr),
    .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
    .i_id_start(i_id_start), .i_id_next(i_id_next), .o_id_data(o_id_data),
    .o_id_valid(o_id_valid), .o_id_busy(o_id_busy));

// ---- id_host_model.sv ----
// Host model that drains identification words
`timescale 1ns/10ps
module id_host_model (
    input wire logic        i_clk,
    input wire logic        i_arst_n,
    input wire logic        i_valid,
    input wire logic [15:0] i_data,
    input wire logic [3:0]  i_stall,
    output logic            o_next
);
    logic [15:0] words [256];
    logic [7:0]  count;
    logic [3:0]  wait_r;
    logic        feat_given;
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_next <= 1'b0;
            count <= 8'h00;
            wait_r <= 4'h0;
            feat_given <= 1'b0;
        end else if (o_next) begin
            o_next <= 1'b0;
            words[count] <= i_data;
            count <= count + 8'h01;
            if (count == 8'h52) feat_given <= i_data != 16'h0000 && i_data != 16'hFFFF;
        end else if (i_valid && wait_r >= i_stall) begin
            o_next <= 1'b1;
            wait_r <= 4'h0;
        end else if (i_valid) wait_r <= wait_r + 4'h1;
    end
endmodule : id_host_model

// ---- tb_identify_data_generator.sv ----
// Self-checking bench for the identification word generator
`timescale 1ns/10ps
module tb_identify_data_generator;
    localparam logic [15:0] DC = 16'h0100, DH = 16'h0010, DS = 16'h003F;
    localparam logic [15:0] CC = 16'h0200, CH = 16'h0010, CS = 16'h0020;
    localparam logic [31:0] TOT = 32'h0012_3456;
    localparam logic [31:0] CAP = CC * CH * CS;
    localparam logic [23:0] FIX [17] = '{24'h05_0240, 24'h14_0002, 24'h15_0002, 24'h16_0004,
        24'h2F_0001, 24'h30_0000, 24'h31_0200, 24'h33_0200, 24'h35_0003, 24'h40_0003,
        24'h43_0078, 24'h44_0078, 24'h52_706A, 24'h53_400C, 24'h54_4000, 24'h57_4000, 24'hA3_0082};
    logic i_clk = 1'b0, i_arst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, start = 1'b0;
    logic [3:0] sel = 4'hF, stall = 4'h0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0000_0000, rdat;
    logic ack, nxt, idv, busy;
    logic [15:0] idd, ex [256];
    logic [7:0] ser [3] = '{8'h41, 8'h42, 8'h43}, mdl [2] = '{8'h58, 8'h59};
    int mismatches = 0, checked = 0;
    always #50 i_clk = ~i_clk;
    identify_data_generator dut (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_wb_cyc(cyc), .i_wb_stb(stb),
        .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat),
        .o_wb_ack(ack), .i_id_start(start), .i_id_next(nxt), .o_id_data(idd),
        .o_id_valid(idv), .o_id_busy(busy));
    id_host_model host (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_valid(idv), .i_data(idd),
        .i_stall(stall), .o_next(nxt));
    task automatic cmp(input string nm, input int i, input logic [31:0] s, e);
        checked++;
        if (s !== e) begin
            mismatches++;
            $display("unexpected %s %0d expected %h seen %h", nm, i, e, s);
        end
    endtask : cmp
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin @(posedge i_clk); end while (ack !== 1'b1);
        if (!w) cmp("read", a, rdat, d);
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge i_clk);
    endtask : wb
    task automatic run_id(input logic [3:0] s, input logic [2:0] c);
        int n = 0;
        for (int i = 0; i < 256; i++) ex[i] = 16'h0000;
        foreach (FIX[i]) ex[FIX[i][23:16]] = FIX[i][15:0];
        for (int i = 0; i < 20; i++) ex[10+i/2] = {ex[10+i/2][7:0], i > 16 ? ser[i-17] : 8'h20};
        for (int i = 0; i < 40; i++) ex[27+i/2] = {ex[27+i/2][7:0], i < 2 ? mdl[i] : 8'h20};
        for (int i = 23; i < 27; i++) ex[i] = 16'h2020;
        ex[1] = DC;
        ex[3] = DH;
        ex[6] = DS;
        ex[54] = CC;
        ex[55] = CH;
        ex[56] = CS;
        ex[164] = 16'h001B;
        {ex[7], ex[8]} = TOT;
        {ex[61], ex[60]} = TOT;
        {ex[58], ex[57]} = CAP;
        ex[59] = {15'h0080, c[0]};
        ex[85] = 16'h7068 | {14'h0000, c[1], 1'b0};
        ex[86] = 16'h0004 | {12'h000, c[2], 3'h0};
        stall <= s;
        start <= 1'b1;
        @(posedge i_clk);
        start <= 1'b0;
        do begin @(posedge i_clk); n++; end while (busy !== 1'b0 || n < 3);
        for (int w = 0; w < 256; w++)
            if (!(w inside {80, 89, 90, 91, 160})) cmp("word", w, host.words[w], ex[w]);
        cmp("feature info", 82, host.feat_given, 32'h0000_0001);
        $display("identify run done, stall %0d", s);
    endtask : run_id
    task end_sim;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : end_sim
    initial begin
        repeat (2) @(posedge i_clk);
        i_arst_n <= 1'b1;
        repeat (3) @(posedge i_clk);
        wb(1'b0, id_gen_pkg::CTRL_OFS, 32'h0000_0006);
        wb(1'b0, 8'h3C, 32'h0000_0000);
        wb(1'b1, id_gen_pkg::DEF_CH_OFS, {DH, DC});
        wb(1'b1, id_gen_pkg::DEF_SPT_OFS, {16'h0000, DS});
        wb(1'b1, id_gen_pkg::TOTAL_OFS, TOT);
        wb(1'b1, id_gen_pkg::CUR_CH_OFS, {CH, CC});
        wb(1'b1, id_gen_pkg::CUR_SPT_OFS, {16'h0000, CS});
        wb(1'b1, id_gen_pkg::STRLEN_OFS, 32'h0002_0003);
        for (int i = 0; i < 3; i++) wb(1'b1, id_gen_pkg::STRWR_OFS, {16'h0000, ser[i], 8'(i)});
        for (int i = 0; i < 2; i++) wb(1'b1, id_gen_pkg::STRWR_OFS, {16'h0000, mdl[i], 8'(64+i)});
        run_id(4'h0, 3'h6);
        wb(1'b1, id_gen_pkg::CTRL_OFS, 32'h0000_0001);
        run_id(4'h3, 3'h1);
        wb(1'b0, id_gen_pkg::STATUS_OFS, 32'h0001_0000);
        wb(1'b0, id_gen_pkg::TOTAL_OFS, TOT);
        wb(1'b1, id_gen_pkg::STRLEN_OFS, 32'h003F_001F);
        wb(1'b0, id_gen_pkg::STRLEN_OFS, 32'h0028_0014);
        $display("register readback done");
        end_sim;
    end
    initial begin
        repeat (10000) @(posedge i_clk);
        mismatches++;
        end_sim;
    end
endmodule : tb_identify_data_generator
